// >>> ofl_pkg.sv
// Constants and types for the output clock default frequency loader.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package ofl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int unsigned OFL_ADDR_W = 8;
   localparam int unsigned OFL_DATA_W = 32;
   localparam logic [1:0] OFL_RESP_OKAY = 2'h0;
   localparam logic [1:0] OFL_RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFL_MAIN_LOOP_CFG = 8'h00;
   localparam logic [7:0] OFL_AUX_LOOP_CFG = 8'h04;
   localparam logic [7:0] OFL_SE_OUT_CFG = 8'h08;
   localparam logic [7:0] OFL_DIFF_OUT_CFG = 8'h0C;
   localparam logic [7:0] OFL_PIN_DIR = 8'h10;
   localparam logic [7:0] OFL_PIN_SEL = 8'h14;
   localparam logic [7:0] OFL_PIN_OUT = 8'h18;
   localparam logic [7:0] OFL_PIN_IN = 8'h1C;
   localparam logic [7:0] OFL_STRAP_CAP = 8'h20;

   ////////////////////////////////////////////////////////////////////////
   // Field positions in the output config registers
   localparam int unsigned OFL_CODE_LSB = 0;
   localparam int unsigned OFL_SRC_BIT = 4;

   ////////////////////////////////////////////////////////////////////////
   // Strap and field encodings
   localparam logic [2:0] OFL_STRAP_000 = 3'h0;
   localparam logic [2:0] OFL_STRAP_001 = 3'h1;
   localparam logic [2:0] OFL_STRAP_010 = 3'h2;
   localparam logic [2:0] OFL_STRAP_111 = 3'h7;
   localparam logic [2:0] OFL_MAIN_E1 = 3'h2;
   localparam logic [2:0] OFL_MAIN_DS1 = 3'h4;
   localparam logic [2:0] OFL_MAIN_7776 = 3'h1;
   localparam logic [3:0] OFL_AUX_E3 = 4'h6;
   localparam logic [3:0] OFL_AUX_DS3 = 4'h7;
   localparam logic [3:0] OFL_AUX_16E1 = 4'h3;
   localparam logic [3:0] OFL_AUX_16DS1 = 4'h5;
   localparam logic [3:0] OFL_CODE_OFF = 4'h0;
   localparam logic [3:0] OFL_CODE_68736 = 4'hF;
   localparam logic [3:0] OFL_CODE_22368 = 4'hE;
   localparam logic [3:0] OFL_CODE_15552 = 4'h3;
   localparam logic [3:0] OFL_CODE_SE_AUX = 4'hD;
   localparam logic [3:0] OFL_CODE_SE_MAIN = 4'h7;
   localparam logic [3:0] OFL_DIFF_BASE = 4'h4;
   localparam logic [3:0] OFL_SE_BASE = 4'h3;
   localparam logic OFL_SRC_MAIN = 1'b0;
   localparam logic OFL_SRC_AUX = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Reset values before the straps are loaded
   localparam logic [5:0] OFL_PIN_RST = 6'h00;

   typedef struct packed {
      logic [2:0] main_freq;
      logic [3:0] aux_freq;
      logic se_src;
      logic [3:0] se_code;
      logic diff_src;
      logic [3:0] diff_code;
   } ofl_cfg_t;

   localparam ofl_cfg_t OFL_CFG_RST = '{3'h1, 4'h3, 1'b0, 4'h0, 1'b0, 4'h0};

endpackage : ofl_pkg

// >>> ofl_loader.sv
// Strap decoder and config register file for the two output clocks.
// Assumes straps and the rate-family pin are synchronous to ref_clk and
// stable while nrst is low; AXI4-Lite master on the register side.
//
// Behaviour
// - Strap groups pick single-ended and differential defaults
// - Rate-family pin picks SDH or SONET rate
// - After reset strap pins become GPIO/status
// - Straps only set defaults; writes override them
// - Main APLL field default from both straps
// - Aux APLL field default from straps
// - Differential output code and source decode
// - Open differential straps give 155.52 MHz
// - Single-ended output code and source decode
// - Open single-ended straps give 19.44 MHz
`timescale 1ns/1ps
`default_nettype none

module ofl_loader
   import ofl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [OFL_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [OFL_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [OFL_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [OFL_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [2:0] single_ended_out_freq_straps_in,
   output logic [2:0] single_ended_out_freq_straps_out,
   output logic [2:0] single_ended_out_freq_straps_oe,
   input wire logic [2:0] differential_out_freq_straps_in,
   output logic [2:0] differential_out_freq_straps_out,
   output logic [2:0] differential_out_freq_straps_oe,
   input wire logic rate_family_pin,
   output ofl_cfg_t cfg_out,
   output logic loaded
);

   ////////////////////////////////////////////////////////////////////////
   // State
   ofl_cfg_t cfg_r;
   ofl_cfg_t cfg_nxt;
   ofl_cfg_t dflt;
   logic loaded_r;
   logic [2:0] se_cap_r;
   logic [2:0] diff_cap_r;
   logic rf_cap_r;
   logic [5:0] pin_dir_r;
   logic [5:0] pin_sel_r;
   logic [5:0] pin_out_r;
   logic [5:0] pin_drv_r;
   logic [5:0] pin_oe_r;
   logic [5:0] pin_dir_nxt;
   logic [5:0] pin_sel_nxt;
   logic [5:0] pin_out_nxt;
   logic [5:0] status_bits;
   logic [5:0] pin_drv_nxt;
   logic [5:0] pin_oe_nxt;

   logic [OFL_ADDR_W-1:0] awaddr_r;
   logic [OFL_DATA_W-1:0] wdata_r;
   logic [3:0] wstrb_r;
   logic aw_full_r;
   logic w_full_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [OFL_DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;

   ////////////////////////////////////////////////////////////////////////
   // Strap decode, from the live pins during the load cycle
   wire logic [2:0] se_s = single_ended_out_freq_straps_in;
   wire logic [2:0] df_s = differential_out_freq_straps_in;
   wire logic rf = rate_family_pin;
   wire logic df_is1 = (df_s == OFL_STRAP_001);
   wire logic se_is1 = (se_s == OFL_STRAP_001);
   wire logic se_is2 = (se_s == OFL_STRAP_010);

   wire logic [2:0] main_dflt = (df_is1 && se_is1)
      ? (rf ? OFL_MAIN_DS1 : OFL_MAIN_E1) : OFL_MAIN_7776;

   wire logic [3:0] aux_dflt = (df_is1 || se_is2)
      ? (rf ? OFL_AUX_DS3 : OFL_AUX_E3)
      : (rf ? OFL_AUX_16DS1 : OFL_AUX_16E1);

   // Linear stretch 010..110 maps to 0110..1010; open pins give 155.52
   wire logic [3:0] diff_lin = {1'b0, df_s} + OFL_DIFF_BASE;
   wire logic [3:0] diff_dflt =
      (df_s == OFL_STRAP_000) ? OFL_CODE_OFF :
      df_is1 ? (rf ? OFL_CODE_22368 : OFL_CODE_68736) :
      (df_s == OFL_STRAP_111) ? OFL_CODE_15552 :
      diff_lin;
   wire logic diff_src_dflt = df_is1 ? OFL_SRC_AUX : OFL_SRC_MAIN;

   // Linear stretch 011..111 maps to 0110..1010; open pins give 19.44
   wire logic [3:0] se_lin = {1'b0, se_s} + OFL_SE_BASE;
   wire logic [3:0] se_dflt =
      (se_s == OFL_STRAP_000) ? OFL_CODE_OFF :
      se_is1 ? (df_is1 ? OFL_CODE_SE_MAIN : OFL_CODE_SE_AUX) :
      se_is2 ? (rf ? OFL_CODE_22368 : OFL_CODE_68736) :
      se_lin;
   // Main APLL sharing: SE 001 moves to main when differential owns aux
   wire logic se_src_dflt = ((se_is1 && !df_is1) || se_is2)
      ? OFL_SRC_AUX : OFL_SRC_MAIN;

   assign dflt = '{main_dflt, aux_dflt, se_src_dflt, se_dflt,
                   diff_src_dflt, diff_dflt};

   ////////////////////////////////////////////////////////////////////////
   // Write channel
   wire logic aw_take = s_axi_awvalid && awready_r;
   wire logic w_take = s_axi_wvalid && wready_r;
   wire logic do_write = aw_full_r && w_full_r && !bvalid_r;
   wire logic aw_full_nxt = aw_full_r ? !do_write : aw_take;
   wire logic w_full_nxt = w_full_r ? !do_write : w_take;
   wire logic lane0 = wstrb_r[0];
   wire logic [7:0] wbyte = wdata_r[7:0];
   wire logic wr_main = do_write && lane0 && (awaddr_r == OFL_MAIN_LOOP_CFG);
   wire logic wr_aux = do_write && lane0 && (awaddr_r == OFL_AUX_LOOP_CFG);
   wire logic wr_se = do_write && lane0 && (awaddr_r == OFL_SE_OUT_CFG);
   wire logic wr_diff = do_write && lane0 && (awaddr_r == OFL_DIFF_OUT_CFG);
   wire logic wr_dir = do_write && lane0 && (awaddr_r == OFL_PIN_DIR);
   wire logic wr_sel = do_write && lane0 && (awaddr_r == OFL_PIN_SEL);
   wire logic wr_out = do_write && lane0 && (awaddr_r == OFL_PIN_OUT);
   wire logic wr_hit = (awaddr_r == OFL_MAIN_LOOP_CFG)
      || (awaddr_r == OFL_AUX_LOOP_CFG) || (awaddr_r == OFL_SE_OUT_CFG)
      || (awaddr_r == OFL_DIFF_OUT_CFG) || (awaddr_r == OFL_PIN_DIR)
      || (awaddr_r == OFL_PIN_SEL) || (awaddr_r == OFL_PIN_OUT)
      || (awaddr_r == OFL_PIN_IN) || (awaddr_r == OFL_STRAP_CAP);

   ////////////////////////////////////////////////////////////////////////
   // Config next value: load once, then software owns the fields
   always_comb
   begin
      cfg_nxt = cfg_r;
      if (!loaded_r)
      begin
         cfg_nxt = dflt;
      end
      else
      begin
         if (wr_main)
         begin
            cfg_nxt.main_freq = wbyte[2:0];
         end
         if (wr_aux)
         begin
            cfg_nxt.aux_freq = wbyte[3:0];
         end
         if (wr_se)
         begin
            cfg_nxt.se_code = wbyte[OFL_CODE_LSB +: 4];
            cfg_nxt.se_src = wbyte[OFL_SRC_BIT];
         end
         if (wr_diff)
         begin
            cfg_nxt.diff_code = wbyte[OFL_CODE_LSB +: 4];
            cfg_nxt.diff_src = wbyte[OFL_SRC_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin block: SE straps on bits 2:0, differential on bits 5:3
   assign pin_dir_nxt = wr_dir ? wbyte[5:0] : pin_dir_r;
   assign pin_sel_nxt = wr_sel ? wbyte[5:0] : pin_sel_r;
   assign pin_out_nxt = wr_out ? wbyte[5:0] : pin_out_r;
   assign status_bits = {cfg_r.diff_code == OFL_CODE_OFF,
                         cfg_r.se_code == OFL_CODE_OFF,
                         rf_cap_r, cfg_r.diff_src, cfg_r.se_src, loaded_r};

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++)
      begin : g_pin
         // Pins stay inputs until the straps are safely captured
         assign pin_oe_nxt[gi] = loaded_r && pin_dir_nxt[gi];
         assign pin_drv_nxt[gi] = pin_sel_nxt[gi]
            ? status_bits[gi] : pin_out_nxt[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read decode
   wire logic ar_take = s_axi_arvalid && arready_r;
   wire logic rvalid_nxt = rvalid_r ? !s_axi_rready : ar_take;
   wire logic [OFL_ADDR_W-1:0] ra = s_axi_araddr;
   wire logic [5:0] pin_in = {differential_out_freq_straps_in,
                              single_ended_out_freq_straps_in};
   wire logic [OFL_DATA_W-1:0] rd_word =
      (ra == OFL_MAIN_LOOP_CFG) ? {29'h0, cfg_r.main_freq} :
      (ra == OFL_AUX_LOOP_CFG) ? {28'h0, cfg_r.aux_freq} :
      (ra == OFL_SE_OUT_CFG) ? {27'h0, cfg_r.se_src, cfg_r.se_code} :
      (ra == OFL_DIFF_OUT_CFG) ? {27'h0, cfg_r.diff_src, cfg_r.diff_code} :
      (ra == OFL_PIN_DIR) ? {26'h0, pin_dir_r} :
      (ra == OFL_PIN_SEL) ? {26'h0, pin_sel_r} :
      (ra == OFL_PIN_OUT) ? {26'h0, pin_out_r} :
      (ra == OFL_PIN_IN) ? {26'h0, pin_in} :
      (ra == OFL_STRAP_CAP) ? {25'h0, rf_cap_r, diff_cap_r, se_cap_r} :
      32'h0000_0000;
   wire logic rd_hit = (ra == OFL_MAIN_LOOP_CFG)
      || (ra == OFL_AUX_LOOP_CFG) || (ra == OFL_SE_OUT_CFG)
      || (ra == OFL_DIFF_OUT_CFG) || (ra == OFL_PIN_DIR)
      || (ra == OFL_PIN_SEL) || (ra == OFL_PIN_OUT)
      || (ra == OFL_PIN_IN) || (ra == OFL_STRAP_CAP);

   ////////////////////////////////////////////////////////////////////////
   // Strap capture and config registers
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         loaded_r <= 1'b0;
         se_cap_r <= 3'h0;
         diff_cap_r <= 3'h0;
         rf_cap_r <= 1'b0;
         cfg_r <= OFL_CFG_RST;
      end
      else
      begin
         loaded_r <= 1'b1;
         cfg_r <= cfg_nxt;
         if (!loaded_r)
         begin
            se_cap_r <= single_ended_out_freq_straps_in;
            diff_cap_r <= differential_out_freq_straps_in;
            rf_cap_r <= rate_family_pin;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_dir_r <= OFL_PIN_RST;
         pin_sel_r <= OFL_PIN_RST;
         pin_out_r <= OFL_PIN_RST;
         pin_drv_r <= OFL_PIN_RST;
         pin_oe_r <= OFL_PIN_RST;
      end
      else
      begin
         pin_dir_r <= pin_dir_nxt;
         pin_sel_r <= pin_sel_nxt;
         pin_out_r <= pin_out_nxt;
         pin_drv_r <= pin_drv_nxt;
         pin_oe_r <= pin_oe_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI write side; held off until straps are loaded
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= OFL_RESP_OKAY;
      end
      else
      begin
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         awready_r <= loaded_r && !aw_full_nxt;
         wready_r <= loaded_r && !w_full_nxt;
         if (aw_take)
         begin
            awaddr_r <= s_axi_awaddr;
         end
         if (w_take)
         begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_write)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? OFL_RESP_OKAY : OFL_RESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            bvalid_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI read side; one read in flight
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= OFL_RESP_OKAY;
      end
      else
      begin
         arready_r <= loaded_r && !rvalid_nxt && !ar_take;
         rvalid_r <= rvalid_nxt;
         if (ar_take)
         begin
            rdata_r <= rd_word;
            rresp_r <= rd_hit ? OFL_RESP_OKAY : OFL_RESP_SLVERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign single_ended_out_freq_straps_out = pin_drv_r[2:0];
   assign single_ended_out_freq_straps_oe = pin_oe_r[2:0];
   assign differential_out_freq_straps_out = pin_drv_r[5:3];
   assign differential_out_freq_straps_oe = pin_oe_r[5:3];
   assign cfg_out = cfg_r;
   assign loaded = loaded_r;

endmodule : ofl_loader

`default_nettype wire

// >>> ofl_loader_props.sv
// Port checker for ofl_loader: strap decode, field hold, bus answers.
// Bound to every ofl_loader; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module ofl_loader_props
   import ofl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [OFL_DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [2:0] single_ended_out_freq_straps_in,
   input wire logic [2:0] single_ended_out_freq_straps_oe,
   input wire logic [2:0] differential_out_freq_straps_in,
   input wire logic [2:0] differential_out_freq_straps_oe,
   input wire logic rate_family_pin,
   input wire ofl_cfg_t cfg_out,
   input wire logic loaded
);
   ////////////////////////////////////////////////////////////////////////
   // Expected defaults from the live pins, judged one edge later
   wire logic [2:0] se = single_ended_out_freq_straps_in;
   wire logic [2:0] df = differential_out_freq_straps_in;
   wire logic rf = rate_family_pin;
   wire logic [2:0] mn_x = (se == 3'h1 && df == 3'h1) ?
      (rf ? 3'h4 : 3'h2) : 3'h1;
   wire logic [3:0] ax_x = (df == 3'h1 || se == 3'h2) ?
      (rf ? 4'h7 : 4'h6) : (rf ? 4'h5 : 4'h3);
   wire logic [4:0] se_x = {(se == 3'h1 && df != 3'h1) || se == 3'h2,
      se == 3'h0 ? 4'h0 : se == 3'h1 ? (df == 3'h1 ? 4'h7 : 4'hD) :
      se == 3'h2 ? (rf ? 4'hE : 4'hF) : {1'b0, se} + 4'h3};
   wire logic [4:0] df_x = {df == 3'h1, df == 3'h0 ? 4'h0 :
      df == 3'h1 ? (rf ? 4'hE : 4'hF) : df == 3'h7 ? 4'h3 :
      {1'b0, df} + 4'h4};
   wire logic [5:0] oe = {differential_out_freq_straps_oe,
      single_ended_out_freq_straps_oe};

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   a_main_default: assert property ($rose(loaded) |->
      cfg_out.main_freq == $past(mn_x)) else $error("main field default");
   a_aux_default: assert property ($rose(loaded) |->
      cfg_out.aux_freq == $past(ax_x)) else $error("aux field default");
   a_se_default: assert property ($rose(loaded) |->
      {cfg_out.se_src, cfg_out.se_code} == $past(se_x))
      else $error("single-ended default");
   a_diff_default: assert property ($rose(loaded) |->
      {cfg_out.diff_src, cfg_out.diff_code} == $past(df_x))
      else $error("differential default");
   a_cfg_hold: assert property (loaded && $past(loaded) &&
      !$stable(cfg_out) |-> $rose(s_axi_bvalid)) else $error("cfg moved");
   a_pins_free: assert property ($rose(loaded) |->
      (oe == 6'h00) [*3]) else $error("pins driven after reset");
   a_bus_idle: assert property (!loaded |-> !s_axi_awready &&
      !s_axi_wready && !s_axi_arready) else $error("bus open early");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read not answered");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");

   c_load: cover property ($rose(loaded));
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : ofl_loader_props

bind ofl_loader ofl_loader_props chk_u (.ref_clk, .nrst, .s_axi_awready,
   .s_axi_wready, .s_axi_arvalid, .s_axi_arready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .single_ended_out_freq_straps_in, .single_ended_out_freq_straps_oe,
   .differential_out_freq_straps_in, .differential_out_freq_straps_oe,
   .rate_family_pin, .cfg_out, .loaded);
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for ofl_loader: strap table, bus access, pins.
// Pins resolve from device enables against bench strap drive.
`timescale 1ns/1ps
`default_nettype none

module testbench
   import ofl_pkg::*;
;
   typedef struct packed {
      logic [2:0] se;
      logic [2:0] df;
      logic rf;
      ofl_cfg_t c;
   } ofl_row_t;
   localparam int NR = 11;
   localparam ofl_row_t ROWS [NR] = '{
      '{3'h0, 3'h0, 1'b0, {3'h1, 4'h3, 1'b0, 4'h0, 1'b0, 4'h0}},
      '{3'h1, 3'h1, 1'b0, {3'h2, 4'h6, 1'b0, 4'h7, 1'b1, 4'hF}},
      '{3'h1, 3'h1, 1'b1, {3'h4, 4'h7, 1'b0, 4'h7, 1'b1, 4'hE}},
      '{3'h1, 3'h0, 1'b1, {3'h1, 4'h5, 1'b1, 4'hD, 1'b0, 4'h0}},
      '{3'h2, 3'h2, 1'b0, {3'h1, 4'h6, 1'b1, 4'hF, 1'b0, 4'h6}},
      '{3'h2, 3'h3, 1'b1, {3'h1, 4'h7, 1'b1, 4'hE, 1'b0, 4'h7}},
      '{3'h3, 3'h4, 1'b0, {3'h1, 4'h3, 1'b0, 4'h6, 1'b0, 4'h8}},
      '{3'h4, 3'h6, 1'b1, {3'h1, 4'h5, 1'b0, 4'h7, 1'b0, 4'hA}},
      '{3'h6, 3'h5, 1'b0, {3'h1, 4'h3, 1'b0, 4'h9, 1'b0, 4'h9}},
      '{3'h7, 3'h7, 1'b1, {3'h1, 4'h5, 1'b0, 4'hA, 1'b0, 4'h3}},
      '{3'h2, 3'h1, 1'b1, {3'h1, 4'h7, 1'b1, 4'hE, 1'b1, 4'hE}}};

   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic rate_family_pin = 1'b0;
   logic [2:0] se_drv = 3'h0, df_drv = 3'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, loaded;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rd;
   logic [2:0] se_out, se_oe, df_out, df_oe;
   ofl_cfg_t cfg_out;
   int error_cnt = 0;
   int total_checks = 0;
   // Pin level: device wins where it enables, else the strap drive
   wire logic [2:0] se_in = (se_oe & se_out) | (~se_oe & se_drv);
   wire logic [2:0] df_in = (df_oe & df_out) | (~df_oe & df_drv);

   always #4 ref_clk = ~ref_clk;

   ofl_loader dut_u (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .single_ended_out_freq_straps_in(se_in),
      .single_ended_out_freq_straps_out(se_out),
      .single_ended_out_freq_straps_oe(se_oe),
      .differential_out_freq_straps_in(df_in),
      .differential_out_freq_straps_out(df_out),
      .differential_out_freq_straps_oe(df_oe),
      .rate_family_pin, .cfg_out, .loaded);

   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run

   task automatic chk_cfg(input ofl_cfg_t got, input ofl_cfg_t exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t cfg %h exp %h", $time, got, exp);
      end
   endtask : chk_cfg

   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t word %h exp %h", $time, got, exp);
      end
   endtask : chk_w

   // Load fixed one edge after release, so no polling here
   task automatic do_reset();
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk_cfg(cfg_out, OFL_CFG_RST);
      chk_w({31'h0, loaded}, 32'h0);
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk_w({31'h0, loaded}, 32'h1);
   endtask : do_reset

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] sb);
      // No cycle limit of its own; a hang ends at the watchdog
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= sb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rdr

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      for (int i = 0; i < NR; i++)
      begin
         @(posedge ref_clk);
         se_drv <= ROWS[i].se;
         df_drv <= ROWS[i].df;
         rate_family_pin <= ROWS[i].rf;
         do_reset();
         chk_cfg(cfg_out, ROWS[i].c);
      end
      se_drv <= 3'h5;
      df_drv <= 3'h3;
      rate_family_pin <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk_cfg(cfg_out, ROWS[NR-1].c);
      rdr(OFL_STRAP_CAP);
      chk_w(rd, 32'h4A);
      wr(OFL_MAIN_LOOP_CFG, 32'h5, 4'h1);
      wr(OFL_AUX_LOOP_CFG, 32'h9, 4'hF);
      // Single-ended stays on the aux APLL: no main-only high rates
      wr(OFL_SE_OUT_CFG, 32'h1A, 4'h1);
      wr(OFL_DIFF_OUT_CFG, 32'h0C, 4'h1);
      chk_w({30'h0, rsp}, {30'h0, OFL_RESP_OKAY});
      // Lane 0 strobe off: write must be dropped
      wr(OFL_MAIN_LOOP_CFG, 32'h7, 4'h0);
      rdr(OFL_SE_OUT_CFG);
      chk_w(rd, 32'h1A);
      chk_cfg(cfg_out, {3'h5, 4'h9, 1'b1, 4'hA, 1'b0, 4'hC});
      wr(8'h40, 32'hFF, 4'hF);
      chk_w({30'h0, rsp}, {30'h0, OFL_RESP_SLVERR});
      rdr(8'h40);
      chk_w({rd[29:0], rsp}, {30'h0, OFL_RESP_SLVERR});
      wr(OFL_PIN_OUT, 32'h2A, 4'h1);
      wr(OFL_PIN_DIR, 32'h3F, 4'h1);
      repeat (3) @(posedge ref_clk);
      chk_w({20'h0, df_oe, se_oe, df_out, se_out}, 32'hFEA);
      wr(OFL_PIN_SEL, 32'h3F, 4'h1);
      repeat (3) @(posedge ref_clk);
      chk_w({26'h0, df_out, se_out}, 32'h0B);
      wr(OFL_PIN_DIR, 32'h0, 4'h1);
      repeat (3) @(posedge ref_clk);
      rdr(OFL_PIN_IN);
      chk_w(rd, 32'h1D);
      do_reset();
      chk_cfg(cfg_out, {3'h1, 4'h3, 1'b0, 4'h8, 1'b0, 4'h7});
      complete_run();
   end

   initial
   begin
      repeat (5000) @(posedge ref_clk);
      error_cnt++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
